// *** rtl/fsac_ctrl.v ***
// Purpose: Register-level controller for self reads, erases and writes of
//          program flash, and reads and user ID writes of the configuration space.
// Assumes: The flash array answers a read combinationally in the same cycle
//          and accepts one latch word per cycle while a row is written.
// Notes:   APB slave with zero wait states; one clock domain.
`timescale 1ns/1ns
`include "fsac_map.vh"

module fsac_ctrl #(
  parameter [31:0] PROG_CYCLES = `FSAC_PROG_CYCLES,
  parameter [13:0] DEVICE_ID   = 14'h1234 // Arbitrary identity value.
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output wire        pslverr_out,
  output wire [31:0] prdata_out,
  input  wire [13:0] cfg_word1_in,
  input  wire [13:0] cfg_word2_in,
  input  wire [13:0] flash_rdata_in,
  output wire        flash_rd_out,
  output wire [14:0] flash_raddr_out,
  output reg         flash_wr_out,
  output reg  [14:0] flash_waddr_out,
  output reg  [13:0] flash_wdata_out,
  output reg         flash_erase_out,
  output wire        busy_out
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_BUSY  = 1'b1;
  localparam NLATCH   = 32;

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [7:0]  data_lo_q;
  reg  [5:0]  data_hi_q;
  reg  [7:0]  addr_lo_q;
  reg  [6:0]  addr_hi_q;
  reg         config_space_select_q;
  reg         latch_load_only_q;
  reg         free_q;
  reg         err_q;
  reg         prog_erase_enable_q;
  reg         wr_q;
  reg         rd_q;
  reg  [1:0]  key_q;
  reg         st_q;
  reg         prog_q;
  reg  [31:0] tmr_q;
  reg  [5:0]  idx_q;
  reg  [13:0] latch_q [0:NLATCH-1];
  reg  [13:0] uid_q [0:3];
  reg  [31:0] prdata_q;
  reg         slverr_q;

  wire [14:0] addr_w  = {addr_hi_q, addr_lo_q};
  wire [13:0] word_w  = {data_hi_q, data_lo_q};
  wire        wr_acc  = psel_in & penable_in & pwrite_in;
  wire        setup   = psel_in & ~penable_in;
  wire        ctl_wr  = wr_acc & (paddr_in == `FSAC_OFS_CONTROL);
  wire        key_wr  = wr_acc & (paddr_in == `FSAC_OFS_UNLOCK);
  wire        wr_try  = ctl_wr & pwdata_in[`FSAC_BIT_WR];
  wire        rd_try  = ctl_wr & pwdata_in[`FSAC_BIT_RD];
  // Offset compare keeps the user ID window test free of an always-true
  // lower bound while the first user ID sits at address zero.
  wire        in_uid  = ((addr_w - `FSAC_UID_FIRST) <=
                         (`FSAC_UID_LAST - `FSAC_UID_FIRST));
  wire        unlocked = (key_q == 2'h2);

  // A start needs the key pair, the enable bit both held and written, and
  // an idle engine; a write that drops the enable never starts the engine.
  wire        start   = wr_try & unlocked & prog_erase_enable_q &
                        pwdata_in[`FSAC_BIT_ENABLE] &
                        (st_q == ST_IDLE) & ~wr_q;
  wire        last_tick = (tmr_q == PROG_CYCLES - 32'h1);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Read data is captured in the setup phase so that the answer in the
  // access phase comes from flip-flops with no wait state.
  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = slverr_q & psel_in & penable_in;
  assign prdata_out  = prdata_q;
  assign busy_out    = wr_q;

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
      case (paddr_in)
        `FSAC_OFS_DATA_LOW:  prdata_q[7:0] <= data_lo_q;
        `FSAC_OFS_DATA_HIGH: prdata_q[7:0] <= {`FSAC_DATAH_FILL,
                                                data_hi_q};
        `FSAC_OFS_ADDR_LOW:  prdata_q[7:0] <= addr_lo_q;
        `FSAC_OFS_ADDR_HIGH: prdata_q[7:0] <= {`FSAC_ADDRH_FILL,
                                                addr_hi_q};
        `FSAC_OFS_CONTROL:   prdata_q[7:0] <= {`FSAC_CTRL_FILL,
                                                config_space_select_q,
                                                latch_load_only_q,
                                                free_q, err_q,
                                                prog_erase_enable_q,
                                                wr_q, rd_q};
        `FSAC_OFS_UNLOCK:    prdata_q[7:0] <= 8'h00;
        default:             slverr_q <= 1'b1;
      endcase
    end
  end

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************
  // Any bus write other than the next key byte breaks the sequence, so a
  // stray write between the keys and the start bit leaves it locked.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      key_q <= 2'h0;
    end else if (key_wr && pwdata_in[7:0] == `FSAC_KEY_FIRST) begin
      key_q <= 2'h1;
    end else if (key_wr && key_q == 2'h1 &&
                 pwdata_in[7:0] == `FSAC_KEY_SECOND) begin
      key_q <= 2'h2;
    end else if (wr_acc) begin
      key_q <= 2'h0;
    end
  end

  // ****************************************************************
  // Config space read mux
  // ****************************************************************
  reg  [13:0] cfg_rd;
  reg         cfg_ok;
  always @* begin
    cfg_rd = 14'h0;
    cfg_ok = 1'b1;
    if (in_uid) begin
      cfg_rd = uid_q[addr_w[1:0]];
    end else if (addr_w == `FSAC_DEVID_ADDR) begin
      cfg_rd = DEVICE_ID;
    end else if (addr_w == `FSAC_CFG1_ADDR) begin
      cfg_rd = cfg_word1_in;
    end else if (addr_w == `FSAC_CFG2_ADDR) begin
      cfg_rd = cfg_word2_in;
    end else begin
      cfg_ok = 1'b0;
    end
  end

  // The array is read in the cycle after the start bit is set.
  assign flash_rd_out    = rd_q & ~config_space_select_q;
  assign flash_raddr_out = addr_w;

  // ****************************************************************
  // Data, address and control registers
  // ****************************************************************
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_lo_q <= 8'h0;
      data_hi_q <= 6'h0;
      addr_lo_q <= 8'h0;
      addr_hi_q <= 7'h0;
      config_space_select_q <= 1'b0;
      latch_load_only_q     <= 1'b0;
      free_q                <= 1'b0;
      err_q                 <= 1'b0;
      prog_erase_enable_q   <= 1'b0;
      rd_q                  <= 1'b0;
    end else begin
      if (wr_acc && paddr_in == `FSAC_OFS_DATA_LOW) begin
        data_lo_q <= pwdata_in[7:0];
      end
      if (wr_acc && paddr_in == `FSAC_OFS_DATA_HIGH) begin
        data_hi_q <= pwdata_in[5:0];
      end
      if (wr_acc && paddr_in == `FSAC_OFS_ADDR_LOW) begin
        addr_lo_q <= pwdata_in[7:0];
      end
      if (wr_acc && paddr_in == `FSAC_OFS_ADDR_HIGH) begin
        addr_hi_q <= pwdata_in[6:0];
      end
      if (ctl_wr) begin
        config_space_select_q <= pwdata_in[`FSAC_BIT_CFG_SEL];
        latch_load_only_q     <= pwdata_in[`FSAC_BIT_LATCH_ONLY];
        prog_erase_enable_q   <= pwdata_in[`FSAC_BIT_ENABLE];
      end
      // Erase select: hardware clear on completion beats software.
      if (st_q == ST_BUSY && last_tick && !prog_q) begin
        free_q <= 1'b0;
      end else if (ctl_wr) begin
        free_q <= pwdata_in[`FSAC_BIT_FREE];
      end
      // Error flag: a set attempt of the start bit wins over everything.
      if (wr_try) begin
        err_q <= 1'b1;
      end else if (st_q == ST_BUSY && last_tick) begin
        err_q <= 1'b0;
      end else if (ctl_wr) begin
        err_q <= pwdata_in[`FSAC_BIT_ERR];
      end
      // Read start: set only by software, cleared after one cycle.
      if (rd_q) begin
        rd_q <= 1'b0;
        if (!config_space_select_q) begin
          data_lo_q <= flash_rdata_in[7:0];
          data_hi_q <= flash_rdata_in[13:8];
        end else if (cfg_ok) begin
          data_lo_q <= cfg_rd[7:0];
          data_hi_q <= cfg_rd[13:8];
        end else begin
          // An address outside the config windows reads back as zero.
          data_lo_q <= 8'h00;
          data_hi_q <= 6'h00;
        end
      end else if (rd_try && st_q == ST_IDLE) begin
        rd_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Write engine
  // ****************************************************************
  // The start bit stays high for the whole self-timed interval; the row
  // stream runs in the first cycles of it, one latch per cycle.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q   <= ST_IDLE;
      wr_q   <= 1'b0;
      prog_q <= 1'b0;
      tmr_q  <= 32'h0;
      idx_q  <= 6'h0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          tmr_q <= 32'h0;
          idx_q <= 6'h0;
          if (start) begin
            wr_q <= 1'b1;
            if (free_q) begin
              st_q   <= ST_BUSY;
              prog_q <= 1'b0;
            end else if (latch_load_only_q || config_space_select_q) begin
              st_q <= ST_IDLE;
            end else begin
              st_q   <= ST_BUSY;
              prog_q <= 1'b1;
            end
          end else begin
            wr_q <= 1'b0;
          end
        end
        ST_BUSY: begin
          tmr_q <= tmr_q + 32'h1;
          if (idx_q != NLATCH[5:0]) begin
            idx_q <= idx_q + 6'h1;
          end
          if (last_tick) begin
            st_q <= ST_IDLE;
            wr_q <= 1'b0;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Array strobes
  // ****************************************************************
  // Addresses keep the row bits, so a row write never leaves its row.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_wr_out    <= 1'b0;
      flash_waddr_out <= 15'h0;
      flash_wdata_out <= 14'h0;
      flash_erase_out <= 1'b0;
    end else begin
      flash_erase_out <= start & free_q &
                         ~config_space_select_q;
      flash_wr_out    <= (st_q == ST_BUSY) & prog_q &
                         (idx_q != NLATCH[5:0]);
      flash_waddr_out <= {addr_w[14:5], idx_q[4:0]};
      flash_wdata_out <= latch_q[idx_q[4:0]];
    end
  end

  // ****************************************************************
  // Write latches and user ID words
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NLATCH; gi = gi + 1) begin : g_latch
      always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          latch_q[gi] <= `FSAC_BLANK_WORD;
        end else if (st_q == ST_BUSY && last_tick) begin
          latch_q[gi] <= `FSAC_BLANK_WORD;
        end else if (start && !free_q && !config_space_select_q &&
                     addr_w[4:0] == gi) begin
          latch_q[gi] <= word_w;
        end
      end
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_uid
      always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          uid_q[gi] <= `FSAC_BLANK_WORD;
        end else if (start && config_space_select_q && in_uid && !free_q &&
                     addr_w[1:0] == gi) begin
          uid_q[gi] <= word_w;
        end
      end
    end
  endgenerate

endmodule // fsac_ctrl

// *** rtl/fsac_map.vh ***
// Purpose: Register map, field positions and timing for the flash access
//          controller.
// Assumes: Included by the controller, its checker and its bench.
// Notes:   Byte addresses are word aligned on the APB bus.
`ifndef FSAC_MAP_VH
`define FSAC_MAP_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define FSAC_OFS_DATA_LOW   8'h00
`define FSAC_OFS_DATA_HIGH  8'h04
`define FSAC_OFS_ADDR_LOW   8'h08
`define FSAC_OFS_ADDR_HIGH  8'h0C
`define FSAC_OFS_CONTROL    8'h10
`define FSAC_OFS_UNLOCK     8'h14

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define FSAC_BIT_RD          0
`define FSAC_BIT_WR          1
`define FSAC_BIT_ENABLE      2
`define FSAC_BIT_ERR         3
`define FSAC_BIT_FREE        4
`define FSAC_BIT_LATCH_ONLY  5
`define FSAC_BIT_CFG_SEL     6

// ****************************************************************
// Values
// ****************************************************************
`define FSAC_KEY_FIRST    8'h55
`define FSAC_KEY_SECOND   8'hAA
`define FSAC_BLANK_WORD   14'h3FFF
`define FSAC_UID_FIRST    15'h0000
`define FSAC_UID_LAST     15'h0003
`define FSAC_DEVID_ADDR   15'h0006
`define FSAC_CFG1_ADDR    15'h0007
`define FSAC_CFG2_ADDR    15'h0008
`define FSAC_ADDRH_FILL   1'h1
`define FSAC_DATAH_FILL   2'h0
`define FSAC_CTRL_FILL    1'h1

// ****************************************************************
// Timing
// ****************************************************************
`define FSAC_CLK_MHZ       100
`define FSAC_PROG_TIME_US  2000
`define FSAC_PROG_CYCLES   (`FSAC_PROG_TIME_US * `FSAC_CLK_MHZ)

`endif

// *** testbench/fsac_asserts.sv ***
// Purpose: Port checker for the flash access controller.
// Assumes: PROG_CYCLES matches the bound instance.
// Notes:   Bound to fsac_ctrl below the module.
`timescale 1ns/1ns
`include "fsac_map.vh"
module fsac_asserts #(
  parameter [31:0] PROG_CYCLES = 40
) (
  input wire        core_clk_in,
  input wire        rst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] pwdata_in,
  input wire [31:0] prdata_out,
  input wire        flash_rd_out,
  input wire        flash_wr_out,
  input wire [14:0] flash_waddr_out,
  input wire        flash_erase_out,
  input wire        busy_out
);
  // ****
  // Helpers
  // ****
  wire       acc = psel_in && penable_in;
  wire       cw  = acc && pwrite_in && paddr_in == `FSAC_OFS_CONTROL;
  reg [31:0] run_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Length of the last busy stretch, read when it ends.
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) run_q <= 32'h0;
    else run_q <= busy_out ? run_q + 32'h1 : 32'h0;
  end
  chk_rd_one_cycle: assert property (
    flash_rd_out |=> !flash_rd_out) else $error("read pulse too long");
  chk_rd_after_set: assert property (
    cw && pwdata_in[0] && !pwdata_in[6] && !busy_out |=> flash_rd_out)
    else $error("read start gave no array read");
  chk_cfg_no_read: assert property (
    cw && pwdata_in[0] && pwdata_in[6] |=> !flash_rd_out)
    else $error("config read reached the array");
  chk_busy_span: assert property (
    $fell(busy_out) |-> (run_q == PROG_CYCLES || run_q == 32'h1))
    else $error("busy stretch has a wrong length");
  chk_row_fixed: assert property (
    flash_wr_out && $past(flash_wr_out) |->
    flash_waddr_out[14:5] == $past(flash_waddr_out[14:5]))
    else $error("row write crossed a row");
  chk_latch_step: assert property (
    flash_wr_out && $past(flash_wr_out) |->
    flash_waddr_out[4:0] == $past(flash_waddr_out[4:0]) + 5'h01)
    else $error("latch index did not step");
  chk_op_in_busy: assert property (
    flash_wr_out || flash_erase_out |-> busy_out)
    else $error("array operation outside busy");
  chk_no_start_off: assert property (
    cw && pwdata_in[1] && !pwdata_in[2] && !busy_out |=> !busy_out)
    else $error("start taken with enable low");
  chk_datah_top: assert property (
    acc && !pwrite_in && paddr_in == `FSAC_OFS_DATA_HIGH |->
    prdata_out[7:6] == 2'h0) else $error("data high top bits set");
  chk_addrh_top: assert property (
    acc && !pwrite_in && paddr_in == `FSAC_OFS_ADDR_HIGH |->
    prdata_out[7]) else $error("address high bit 7 not one");
endmodule // fsac_asserts
bind fsac_ctrl fsac_asserts #(.PROG_CYCLES(PROG_CYCLES)) fsac_asserts_i (
  .core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .flash_rd_out, .flash_wr_out, .flash_waddr_out,
  .flash_erase_out, .busy_out);

// *** testbench/fsac_ctrl_bench.sv ***
// Purpose: Register-level tests of the flash access controller.
// Assumes: Zero wait APB slave.
// Notes:   Short program time keeps the run brief.
`timescale 1ns/1ns
`include "fsac_map.vh"
module fsac_ctrl_bench;
  localparam [7:0] CT = `FSAC_OFS_CONTROL;
  localparam [7:0] UK = `FSAC_OFS_UNLOCK;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         pen = 1'b0;
  reg         pwr = 1'b0;
  reg  [7:0]  pa = 8'h00;
  reg  [31:0] pwd = 32'h0;
  reg  [31:0] rq;
  reg         re;
  wire        prdy, perr, frd, fwr, fer, busy;
  wire [31:0] prd;
  wire [13:0] frdat, fwd;
  wire [14:0] fra, fwa;
  integer     fail_count = 0, n_compared = 0, n_wr = 0, n_er = 0, i;
  always #5 clk = ~clk;
  // Arbitrary identity value.
  fsac_ctrl #(.PROG_CYCLES(40), .DEVICE_ID(14'h0D5E)) fsac_ctrl_i (
    .core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .pready_out(prdy),
    .pslverr_out(perr), .prdata_out(prd), .cfg_word1_in(14'h1ABC),
    .cfg_word2_in(14'h0F0F), .flash_rdata_in(frdat), .flash_rd_out(frd),
    .flash_raddr_out(fra), .flash_wr_out(fwr), .flash_waddr_out(fwa),
    .flash_wdata_out(fwd), .flash_erase_out(fer), .busy_out(busy));
  fsac_flash_model fsac_flash_model_i (
    .core_clk_in(clk), .flash_rd_in(frd), .flash_raddr_in(fra),
    .flash_wr_in(fwr), .flash_waddr_in(fwa), .flash_wdata_in(fwd),
    .flash_erase_in(fer), .flash_rdata_out(frdat));
  // Array pulses are counted to judge what each start did.
  always @(posedge clk) begin
    if (fwr === 1'b1) n_wr <= n_wr + 1;
    if (fer === 1'b1) n_er <= n_er + 1;
  end
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task ck(input string nm, input [31:0] g, input [31:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge.
  task bus(input w, input [7:0] a, input [7:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rq = prd;
    re = perr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    bus(1'b0, a, 8'h00);
    ck("register", rq, {24'h0, e});
  endtask
  task rword(input [14:0] a, input [7:0] c, input [13:0] w);
    bus(1'b1, `FSAC_OFS_ADDR_LOW, a[7:0]);
    bus(1'b1, `FSAC_OFS_ADDR_HIGH, {1'b0, a[14:8]});
    bus(1'b1, CT, c | 8'h01);
    repeat (2) @(posedge clk);
    rdc(`FSAC_OFS_DATA_LOW, w[7:0]);
    rdc(`FSAC_OFS_DATA_HIGH, {2'b00, w[13:8]});
  endtask
  // Key pair sits right before the start write, as software must.
  task prog(input [14:0] a, input [13:0] w, input [7:0] c);
    bus(1'b1, `FSAC_OFS_ADDR_LOW, a[7:0]);
    bus(1'b1, `FSAC_OFS_ADDR_HIGH, {1'b0, a[14:8]});
    bus(1'b1, `FSAC_OFS_DATA_LOW, w[7:0]);
    bus(1'b1, `FSAC_OFS_DATA_HIGH, {2'b00, w[13:8]});
    bus(1'b1, CT, c);
    bus(1'b1, UK, `FSAC_KEY_FIRST);
    bus(1'b1, UK, `FSAC_KEY_SECOND);
    bus(1'b1, CT, c | 8'h02);
    repeat (2) @(posedge clk);
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      @(posedge clk);
      i = i + 1;
    end
    // A start bit that never clears counts as a mismatch here.
    ck("busy end", {31'h0, busy}, 32'h0);
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    $display("CHECK FAILED watchdog exp done got timeout");
    final_report;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(`FSAC_OFS_ADDR_HIGH, 8'h80);
    rdc(`FSAC_OFS_DATA_HIGH, 8'h00);
    rdc(CT, 8'h80);
    bus(1'b0, 8'h18, 8'h00);
    ck("slverr", {31'h0, re}, 32'h1);
    ck("unmapped", rq, 32'h0);
    rword(15'h0125, 8'h00, 14'h0125);
    rdc(CT, 8'h80);
    bus(1'b1, CT, 8'h02);
    rdc(CT, 8'h88);
    // Enable is held first, so only the broken key pair can refuse.
    bus(1'b1, CT, 8'h04);
    bus(1'b1, UK, 8'h55);
    bus(1'b1, `FSAC_OFS_ADDR_LOW, 8'h40);
    bus(1'b1, UK, 8'hAA);
    bus(1'b1, CT, 8'h06);
    rdc(CT, 8'h8C);
    prog(15'h0150, 14'h1111, 8'h00);
    ck("wr off", n_wr, 0);
    prog(15'h0140, 14'h15AB, 8'h24);
    ck("load only", n_wr, 0);
    prog(15'h0142, 14'h0123, 8'h04);
    ck("row", n_wr, 32);
    rdc(CT, 8'h84);
    rword(15'h0140, 8'h04, 14'h15AB);
    rword(15'h0141, 8'h04, 14'h3FFF);
    prog(15'h0143, 14'h0055, 8'h04);
    rword(15'h0140, 8'h04, 14'h3FFF);
    prog(15'h0143, 14'h0000, 8'h34);
    ck("erase", n_er, 1);
    ck("no row", n_wr, 64);
    rdc(CT, 8'hA4);
    rword(15'h0143, 8'h04, 14'h3FFF);
    rword(15'h0002, 8'h40, 14'h3FFF);
    prog(15'h0002, 14'h0567, 8'h44);
    rword(15'h0002, 8'h40, 14'h0567);
    rword(15'h0006, 8'h40, 14'h0D5E);
    rword(15'h0008, 8'h40, 14'h0F0F);
    prog(15'h0007, 14'h0000, 8'h44);
    rword(15'h0007, 8'h40, 14'h1ABC);
    rword(15'h0004, 8'h40, 14'h0000);
    // An erase with the config select set must not touch the array.
    prog(15'h0002, 14'h0000, 8'h54);
    ck("cfg erase", n_er, 1);
    rword(15'h0002, 8'h40, 14'h0567);
    ck("cfg", n_wr, 64);
    final_report;
  end
endmodule // fsac_ctrl_bench

// *** testbench/fsac_flash_model.sv ***
// Purpose: Behavioural program flash array for the bench.
// Assumes: Word i starts out holding the low 14 bits of i.
// Notes:   Outside a read the data lines show the inverse word.
`timescale 1ns/1ns
module fsac_flash_model (
  input  wire        core_clk_in,
  input  wire        flash_rd_in,
  input  wire [14:0] flash_raddr_in,
  input  wire        flash_wr_in,
  input  wire [14:0] flash_waddr_in,
  input  wire [13:0] flash_wdata_in,
  input  wire        flash_erase_in,
  output wire [13:0] flash_rdata_out
);
  reg [13:0] mem [0:32767];
  integer    k;
  initial for (k = 0; k < 32768; k = k + 1) mem[k] = k[13:0];
  // Inverted data off reads, so a stale sample cannot pass.
  assign flash_rdata_out = flash_rd_in ? mem[flash_raddr_in]
                                       : ~mem[flash_raddr_in];
  // Row erase clears the whole row named by the address.
  always @(posedge core_clk_in) begin
    if (flash_wr_in) mem[flash_waddr_in] <= flash_wdata_in;
    if (flash_erase_in)
      for (k = 0; k < 32; k = k + 1)
        mem[{flash_raddr_in[14:5], k[4:0]}] <= 14'h3FFF;
  end
endmodule // fsac_flash_model
